// ===== shared/pil_params.svh
`ifndef PIL_PARAMS_SVH
`define PIL_PARAMS_SVH

// ----------------------------------------------------------------------
// Level indices, lower index ranks higher
// ----------------------------------------------------------------------
`define PIL_N_INT 11
`define PIL_IDX_F 4'h5
`define PIL_IDX_G 4'h6
`define PIL_IDX_H 4'h7
`define PIL_IDX_J 4'h8
`define PIL_IDX_K 4'h9
`define PIL_IDX_S 4'hA
`define PIL_IDX_BASE 4'hB
`define PIL_N_MAINT 7

// ----------------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------------
`define PIL_ADDR_W 16
`define PIL_VEC_BASE 16'h0100
`define PIL_VEC_STRIDE 16'h0040
`define PIL_SAFE_ADDR 16'h0080

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PIL_CLK_HZ 40000000
`define PIL_PERIOD_US 5000
`define PIL_TICK_CYCLES ((`PIL_CLK_HZ / 1000000) * `PIL_PERIOD_US)
`define PIL_S_EVERY 10
`define PIL_CNT_W 4

`endif

// ===== shared/pil_pkg.sv
package pil_pkg;

    // ------------------------------------------------------------------
    // Level codes in descending priority
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PIL_LVL_A = 4'h0,
        PIL_LVL_B = 4'h1,
        PIL_LVL_C = 4'h2,
        PIL_LVL_D = 4'h3,
        PIL_LVL_E = 4'h4,
        PIL_LVL_F = 4'h5,
        PIL_LVL_G = 4'h6,
        PIL_LVL_H = 4'h7,
        PIL_LVL_J = 4'h8,
        PIL_LVL_K = 4'h9,
        PIL_LVL_S = 4'hA,
        PIL_LVL_BASE = 4'hB
    } pil_level_t;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PIL_ST_RUN = 2'h0,
        PIL_ST_POP = 2'h1
    } pil_state_t;

endpackage

// ===== logic/pil_ret_stack.sv
`timescale 1ns/100ps
`include "pil_params.svh"

module pil_ret_stack #(
    parameter int DEPTH = 11,
    parameter int AW = 4,
    parameter int DW = `PIL_ADDR_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // Read port
    input wire logic i_re,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);

    logic [DW-1:0] mem [DEPTH];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Registered read, one cycle after the strobe
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_rdata <= '0;
        end
        else if (i_re)
        begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule // pil_ret_stack

// ===== logic/pil_period_timer.sv
`timescale 1ns/100ps
`include "pil_params.svh"

module pil_period_timer #(
    parameter int CYCLES = `PIL_TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Period pulse
    output logic o_tick
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_r;

    // ------------------------------------------------------------------
    // Free running period counter
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cnt_r <= '0;
            o_tick <= 1'b0;
        end
        else if (cnt_r == CW'(CYCLES - 1))
        begin
            cnt_r <= '0;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + CW'(1);
            o_tick <= 1'b0;
        end
    end

endmodule // pil_period_timer

// ===== logic/pil_sequencer.sv
`timescale 1ns/100ps
`include "pil_params.svh"

// Behaviour
// (R1) Levels A..L without I, plus S; the code has no L and implements A..K without I, plus S
// (R2) Levels A to G carry maintenance
// (R3) H and J do I/O; base otherwise
// (R4) K only with signal processor present
// (R5) Priority falls alphabetically, base lowest
// (R6) Accept only over lower active level
// (R7) Accept: save address, branch to level
// (R8) Done: resume saved address or safe point
// (R9) Each 5 ms tick raises J
// (R10) In J: high programs first, then low
// (R11) J done returns to base level; the code resumes K or S instead when J preempted them
// (R12) Tick during running J raises H
// (R13) H preempts low J, then returns
// (R14) Low programs only in J level
// (R15) Every tenth J enters S, no processor
// (R16) S done returns straight to base
// (R17) S selectable; else scanning in H/J
// (R18) F from mismatch, alarm, scanner failure
// (R19) Lower requests wait, served by rank
module pil_sequencer #(
    parameter int TICK_CYCLES = `PIL_TICK_CYCLES,
    parameter int S_EVERY = `PIL_S_EVERY
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Configuration straps
    input wire logic i_cfg_sigproc_present,
    input wire logic i_cfg_trunk_level_en,
    // Interrupt sources
    input wire logic [`PIL_N_MAINT-1:0] i_maint_req,
    input wire logic i_sigproc_mismatch,
    input wire logic i_periph_alarm,
    input wire logic i_scanner_fail,
    input wire logic i_sigproc_hopper_ovf,
    // Central processor program sequencer
    input wire logic [`PIL_ADDR_W-1:0] i_pc,
    input wire logic i_done,
    input wire logic i_done_safe,
    input wire logic i_hi_io_done,
    output logic o_branch,
    output logic [`PIL_ADDR_W-1:0] o_branch_addr,
    output logic o_resume,
    output logic [`PIL_ADDR_W-1:0] o_resume_addr,
    // Level status
    output pil_pkg::pil_level_t o_level,
    output logic o_base_active,
    output logic o_run_high_io,
    output logic o_run_low_io,
    output logic o_trunk_scan_in_io,
    output logic [`PIL_N_INT-1:0] o_pending
);

    import pil_pkg::*;

    localparam int N = `PIL_N_INT;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Lowest set bit wins; empty mask means base level
    function automatic logic [3:0] top_idx(input logic [N-1:0] m);
        logic [3:0] r;
        r = `PIL_IDX_BASE;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                r = 4'(i);
            end
        end
        return r; // R5
    endfunction

    function automatic logic [`PIL_ADDR_W-1:0] vec_addr(input logic [3:0] idx);
        return `PIL_VEC_BASE + (`PIL_ADDR_W'(idx) * `PIL_VEC_STRIDE);
    endfunction

    pil_state_t state_r;
    logic [N-1:0] pending_r;
    logic [N-1:0] active_r; // R1
    logic [3:0] sp_r;
    logic [`PIL_CNT_W-1:0] j_cnt_r;
    logic s_due_r;
    logic safe_r;
    logic j_hi_done_r;
    logic tick_w;
    logic [`PIL_ADDR_W-1:0] stack_rdata;

    logic [3:0] cur_idx;
    logic [3:0] acc_idx;
    logic [N-1:0] elig_mask;
    logic [N-1:0] set_c;
    logic [N-1:0] clr_c;
    logic accept_c;
    logic done_c;
    logic s_avail;
    logic s_trig;
    logic j_raise;

    // ------------------------------------------------------------------
    // Period timer and return stack
    // ------------------------------------------------------------------
    pil_period_timer #(
        .CYCLES(TICK_CYCLES)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .o_tick(tick_w)
    );

    pil_ret_stack #(
        .DEPTH(N),
        .AW(4),
        .DW(`PIL_ADDR_W)
    ) u_stack (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(accept_c),
        .i_waddr(sp_r),
        .i_wdata(i_pc),
        .i_re(done_c),
        .i_raddr(sp_r - 4'h1),
        .o_rdata(stack_rdata)
    );

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------
    assign s_avail = !i_cfg_sigproc_present && i_cfg_trunk_level_en; // R17
    assign cur_idx = top_idx(active_r);

    always_comb
    begin
        elig_mask = '1;
        elig_mask[`PIL_IDX_K] = i_cfg_sigproc_present; // R4
        elig_mask[`PIL_IDX_S] = s_avail; // R15
    end

    // Equal or lower rank stays pending until higher levels finish
    assign acc_idx = top_idx(pending_r & elig_mask); // R19
    assign accept_c = (state_r == PIL_ST_RUN) && !i_done && (acc_idx < cur_idx); // R6
    assign done_c = (state_r == PIL_ST_RUN) && i_done && (cur_idx != `PIL_IDX_BASE);
    assign j_raise = tick_w && !active_r[`PIL_IDX_J];
    assign s_trig = done_c && (cur_idx == `PIL_IDX_J) && s_due_r && s_avail; // R15

    always_comb
    begin
        set_c = '0;
        set_c[`PIL_N_MAINT-1:0] = i_maint_req; // R2
        if (i_sigproc_mismatch || i_periph_alarm || i_scanner_fail)
        begin
            set_c[`PIL_IDX_F] = 1'b1; // R18
        end
        if (tick_w && active_r[`PIL_IDX_J])
        begin
            set_c[`PIL_IDX_H] = 1'b1; // R12
        end
        if (j_raise)
        begin
            set_c[`PIL_IDX_J] = 1'b1; // R9
        end
        if (i_sigproc_hopper_ovf && i_cfg_sigproc_present)
        begin
            set_c[`PIL_IDX_K] = 1'b1; // R4
        end
        if (s_trig)
        begin
            set_c[`PIL_IDX_S] = 1'b1; // R15
        end
    end

    always_comb
    begin
        clr_c = '0;
        if (accept_c)
        begin
            clr_c[acc_idx] = 1'b1;
        end
    end

    // A new request in the clearing cycle is kept
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pending_r <= '0;
        end
        else
        begin
            pending_r <= (pending_r & ~clr_c) | set_c; // R19
        end
    end

    // ------------------------------------------------------------------
    // Active levels and return stack pointer
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            active_r <= '0;
        end
        else if (accept_c)
        begin
            active_r[acc_idx] <= 1'b1; // R7
        end
        else if (done_c)
        begin
            // S runs only over base; J resumes base unless it preempted K or S
            active_r[cur_idx] <= 1'b0; // R11 R16
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sp_r <= 4'h0;
        end
        else if (accept_c)
        begin
            sp_r <= sp_r + 4'h1; // R7
        end
        else if (done_c)
        begin
            sp_r <= sp_r - 4'h1; // R8
        end
    end

    // ------------------------------------------------------------------
    // Completion sequence
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_r <= PIL_ST_RUN;
            safe_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                PIL_ST_RUN:
                begin
                    if (done_c)
                    begin
                        state_r <= PIL_ST_POP;
                        safe_r <= i_done_safe;
                    end
                end
                PIL_ST_POP:
                begin
                    state_r <= PIL_ST_RUN;
                end
                default:
                begin
                    state_r <= PIL_ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_branch <= 1'b0;
            o_branch_addr <= '0;
        end
        else
        begin
            o_branch <= accept_c; // R7
            if (accept_c)
            begin
                o_branch_addr <= vec_addr(acc_idx); // R7
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_resume <= 1'b0;
            o_resume_addr <= '0;
        end
        else
        begin
            o_resume <= (state_r == PIL_ST_POP); // R8
            if (state_r == PIL_ST_POP)
            begin
                o_resume_addr <= safe_r ? `PIL_SAFE_ADDR : stack_rdata; // R8
            end
        end
    end

    // ------------------------------------------------------------------
    // Periodic work: tenth count and high/low phase
    // ------------------------------------------------------------------
    // Only ticks that raise J count toward the supervision cadence
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            j_cnt_r <= '0;
            s_due_r <= 1'b0;
        end
        else
        begin
            if (j_raise)
            begin
                if (j_cnt_r == `PIL_CNT_W'(S_EVERY - 1))
                begin
                    j_cnt_r <= '0;
                    s_due_r <= 1'b1; // R15
                end
                else
                begin
                    j_cnt_r <= j_cnt_r + `PIL_CNT_W'(1);
                end
            end
            else if (done_c && (cur_idx == `PIL_IDX_J))
            begin
                s_due_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            j_hi_done_r <= 1'b0;
        end
        else if (accept_c && (acc_idx == `PIL_IDX_J))
        begin
            j_hi_done_r <= 1'b0; // R10
        end
        else if (i_hi_io_done && (cur_idx == `PIL_IDX_J))
        begin
            j_hi_done_r <= 1'b1; // R10
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_level <= PIL_LVL_BASE;
            o_base_active <= 1'b1;
            o_run_high_io <= 1'b0;
            o_run_low_io <= 1'b0;
            o_trunk_scan_in_io <= 1'b0;
            o_pending <= '0;
        end
        else
        begin
            o_level <= pil_level_t'(cur_idx);
            o_base_active <= (cur_idx == `PIL_IDX_BASE); // R3
            o_run_high_io <= (cur_idx == `PIL_IDX_H) ||
                             ((cur_idx == `PIL_IDX_J) && !j_hi_done_r); // R13 R14
            o_run_low_io <= (cur_idx == `PIL_IDX_J) && j_hi_done_r; // R14
            o_trunk_scan_in_io <= !s_avail; // R17
            o_pending <= pending_r;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_accept_rank: assert property (accept_c |=> (cur_idx == $past(acc_idx))) // R6
        else $error("accepted level did not become the current level");
    a_branch_vec: assert property (accept_c |=> o_branch &&
        (o_branch_addr == vec_addr($past(acc_idx)))) // R7
        else $error("branch pulse or vector wrong after accept");
    a_resume_lat: assert property (done_c |=> !o_resume ##1 o_resume) // R8
        else $error("resume not two cycles after done");
    a_safe_addr: assert property ((done_c && i_done_safe) |-> ##2
        (o_resume_addr == `PIL_SAFE_ADDR)) // R8
        else $error("safe resume address wrong");
    a_tick_j: assert property (j_raise |=> pending_r[`PIL_IDX_J]) // R9
        else $error("tick did not raise J");
    a_tick_h: assert property ((tick_w && active_r[`PIL_IDX_J]) |=>
        pending_r[`PIL_IDX_H] && !$past(set_c[`PIL_IDX_J])) // R12
        else $error("tick during J did not raise H");
    a_low_only_j: assert property (o_run_low_io |-> (o_level == PIL_LVL_J) &&
        !o_run_high_io) // R14
        else $error("low programs outside J");
    a_k_gated: assert property ((accept_c && (acc_idx == `PIL_IDX_K)) |->
        i_cfg_sigproc_present) // R4
        else $error("K accepted without signal processor");
    a_s_gated: assert property ((accept_c && (acc_idx == `PIL_IDX_S)) |->
        s_avail) // R17
        else $error("S accepted while unavailable");
    a_f_sources: assert property ((i_sigproc_mismatch || i_periph_alarm ||
        i_scanner_fail) |=> pending_r[`PIL_IDX_F]) // R18
        else $error("F not raised by its sources");
    a_s_after_j: assert property (s_trig |=> pending_r[`PIL_IDX_S] &&
        !active_r[`PIL_IDX_J]) // R15
        else $error("S not raised at J completion");
    a_stack_depth: assert property (sp_r <= 4'(N)) // R7
        else $error("return stack overflow");

    c_h_over_j: cover property (accept_c && (acc_idx == `PIL_IDX_H) &&
        active_r[`PIL_IDX_J]);
    c_s_entry: cover property (accept_c && (acc_idx == `PIL_IDX_S));
    c_safe_resume: cover property (done_c && i_done_safe);
    c_maint_nest: cover property (accept_c && (acc_idx < `PIL_IDX_H) &&
        (cur_idx < `PIL_IDX_BASE));

endmodule // pil_sequencer

// ===== dv/pil_cpu_model.sv
`timescale 1ns/100ps
`include "pil_params.svh"

module pil_cpu_model #(
    parameter logic [`PIL_ADDR_W-1:0] START_PC = 16'h4000
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Jumps from the sequencer
    input wire logic i_branch,
    input wire logic [`PIL_ADDR_W-1:0] i_branch_addr,
    input wire logic i_resume,
    input wire logic [`PIL_ADDR_W-1:0] i_resume_addr,
    // Current program address
    output logic [`PIL_ADDR_W-1:0] o_pc
);
    // ------------------------------------------------------------------
    // Program address
    // ------------------------------------------------------------------
    logic [`PIL_ADDR_W-1:0] pc_r;

    // The program parks on the address it jumped to
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            pc_r <= START_PC;
        else if (i_resume)
            pc_r <= i_resume_addr;
        else if (i_branch)
            pc_r <= i_branch_addr;
    end

    // Shown in the jump cycle itself, so an accept on a resume saves the real spot
    assign o_pc = i_resume ? i_resume_addr : (i_branch ? i_branch_addr : pc_r);
endmodule // pil_cpu_model

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`include "pil_params.svh"

module tb_top;
    import pil_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int TICK = 400;
    localparam int LIMIT = 8000;
    logic i_clk, i_rst, cfg_sp, cfg_tr, i_done, i_done_safe;
    logic [11:0] src;
    logic [15:0] i_pc, o_branch_addr, o_resume_addr, base_pc;
    logic o_branch, o_resume, o_base_active, o_run_high_io, o_run_low_io, o_trunk_scan;
    logic [`PIL_N_INT-1:0] o_pending;
    pil_level_t o_level;
    int fail_count, checks, cycles, j_count;

    pil_sequencer #(.TICK_CYCLES(TICK), .S_EVERY(`PIL_S_EVERY)) dut (
        .i_clk(i_clk), .i_rst(i_rst),
        .i_cfg_sigproc_present(cfg_sp), .i_cfg_trunk_level_en(cfg_tr),
        .i_maint_req(src[6:0]), .i_sigproc_mismatch(src[7]), .i_periph_alarm(src[8]),
        .i_scanner_fail(src[9]), .i_sigproc_hopper_ovf(src[10]),
        .i_pc(i_pc), .i_done(i_done), .i_done_safe(i_done_safe), .i_hi_io_done(src[11]),
        .o_branch(o_branch), .o_branch_addr(o_branch_addr),
        .o_resume(o_resume), .o_resume_addr(o_resume_addr),
        .o_level(o_level), .o_base_active(o_base_active), .o_run_high_io(o_run_high_io),
        .o_run_low_io(o_run_low_io), .o_trunk_scan_in_io(o_trunk_scan), .o_pending(o_pending)
    );

    pil_cpu_model cpu (
        .i_clk(i_clk), .i_rst(i_rst), .i_branch(o_branch), .i_branch_addr(o_branch_addr),
        .i_resume(o_resume), .i_resume_addr(o_resume_addr), .o_pc(i_pc)
    );

    // ------------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fail_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_addr(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_lvl(input pil_level_t exp);
        checks++;
        if (o_level !== exp)
        begin
            fail_count++;
            $display("[FAIL] level expected %h seen %h", exp, o_level);
        end
    endtask

    function automatic logic [15:0] vec(input pil_level_t lvl);
        return `PIL_VEC_BASE + {12'h000, lvl} * `PIL_VEC_STRIDE;
    endfunction

    task automatic idle(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic pulse_src(input int which);
        src[which] = 1'b1;
        @(negedge i_clk);
        src = '0;
    endtask

    task automatic finish_lvl(input logic safe);
        i_done = 1'b1;
        i_done_safe = safe;
        @(negedge i_clk);
        i_done = 1'b0;
        i_done_safe = 1'b0;
    endtask

    // Waits for a branch (rs=0) or resume (rs=1) pulse and checks its address
    task automatic wait_out(input logic rs, input logic [15:0] exp, input int lim);
        int n;
        n = 0;
        while (((rs ? o_resume : o_branch) !== 1'b1) && n < lim)
        begin
            @(negedge i_clk);
            n++;
        end
        chk_bit("jump pulse", 1'b1, rs ? o_resume : o_branch);
        chk_addr("jump address", exp, rs ? o_resume_addr : o_branch_addr);
        @(negedge i_clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_reset(input logic sp, input logic tr);
        i_rst = 1'b1;
        cfg_sp = sp;
        cfg_tr = tr;
        src = '0;
        i_done = 1'b0;
        i_done_safe = 1'b0;
        idle(10);
        i_rst = 1'b0;
        base_pc = 16'h4000;
        j_count = 0;
        idle(2);
        chk_lvl(PIL_LVL_BASE);
        chk_bit("base active", 1'b1, o_base_active);
        chk_addr("pending", 16'h0000, {5'h00, o_pending});
        chk_bit("scan in io", !(!sp && tr), o_trunk_scan);
    endtask

    task automatic sc_j_period();
        wait_out(1'b0, vec(PIL_LVL_J), TICK + 20);
        j_count++;
        idle(1);
        chk_bit("high io", 1'b1, o_run_high_io);
        pulse_src(11);
        idle(1);
        chk_bit("low io", 1'b1, o_run_low_io);
        chk_bit("high io", 1'b0, o_run_high_io);
        finish_lvl(1'b0);
        wait_out(1'b1, base_pc, 8);
        if (j_count == `PIL_S_EVERY && !cfg_sp && cfg_tr)
        begin
            wait_out(1'b0, vec(PIL_LVL_S), 8);
            finish_lvl(1'b0);
            wait_out(1'b1, base_pc, 8);
        end
        idle(2);
        chk_bit("base active", 1'b1, o_base_active);
    endtask

    task automatic sc_alarms();
        for (int k = 7; k < 10; k++)
        begin
            pulse_src(k);
            wait_out(1'b0, vec(PIL_LVL_F), 6);
            idle(1);
            chk_lvl(PIL_LVL_F);
            finish_lvl(1'b0);
            wait_out(1'b1, base_pc, 6);
        end
    endtask

    // Lower request waits behind E, higher B nests, safe resume unwinds one
    task automatic sc_nesting();
        pulse_src(4);
        wait_out(1'b0, vec(PIL_LVL_E), 6);
        pulse_src(6);
        idle(3);
        chk_lvl(PIL_LVL_E);
        chk_bit("pending G", 1'b1, o_pending[6]);
        pulse_src(1);
        wait_out(1'b0, vec(PIL_LVL_B), 6);
        finish_lvl(1'b0);
        wait_out(1'b1, vec(PIL_LVL_E), 6);
        idle(1);
        chk_lvl(PIL_LVL_E);
        finish_lvl(1'b1);
        wait_out(1'b1, `PIL_SAFE_ADDR, 6);
        wait_out(1'b0, vec(PIL_LVL_G), 6);
        finish_lvl(1'b0);
        wait_out(1'b1, `PIL_SAFE_ADDR, 6);
        base_pc = `PIL_SAFE_ADDR;
    endtask

    // Periodic work left running past the next tick
    task automatic sc_overrun();
        wait_out(1'b0, vec(PIL_LVL_J), TICK + 20);
        j_count++;
        pulse_src(11);
        idle(1);
        chk_bit("low io", 1'b1, o_run_low_io);
        wait_out(1'b0, vec(PIL_LVL_H), TICK + 20);
        idle(1);
        chk_bit("high io", 1'b1, o_run_high_io);
        chk_bit("low io", 1'b0, o_run_low_io);
        finish_lvl(1'b0);
        wait_out(1'b1, vec(PIL_LVL_J), 6);
        idle(1);
        chk_lvl(PIL_LVL_J);
        chk_bit("low io", 1'b1, o_run_low_io);
        finish_lvl(1'b0);
        wait_out(1'b1, base_pc, 6);
    endtask

    task automatic sc_hopper(input logic sp);
        pulse_src(10);
        if (!sp)
        begin
            idle(3);
            chk_bit("pending K", 1'b0, o_pending[9]);
        end
        else
        begin
            wait_out(1'b0, vec(PIL_LVL_K), 6);
            finish_lvl(1'b0);
            wait_out(1'b1, base_pc, 6);
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        fail_count = 0;
        checks = 0;
        cycles = 0;
        sc_reset(1'b0, 1'b1);
        sc_hopper(1'b0);
        sc_j_period();
        sc_alarms();
        sc_j_period();
        sc_nesting();
        sc_overrun();
        repeat (7) sc_j_period();
        sc_reset(1'b0, 1'b0);
        sc_hopper(1'b0);
        sc_reset(1'b1, 1'b1);
        sc_hopper(1'b1);
        finish_test();
    end
endmodule // tb_top
